//--- design/lens_actuator_drive.sv
// lens actuator drive: config variables, stepper waveforms, homing, pad routing
`timescale 1ns/1ns
module lens_actuator_drive import lens_drive_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] var_addr,
  input wire logic var_wr,
  input wire logic [7:0] var_wdata,
  output logic [7:0] var_rdata,
  input wire logic si_req,
  input wire logic [15:0] si_data,
  output logic si_busy,
  output logic si_nack,
  input wire logic step_req,
  input wire logic step_up,
  input wire logic [7:0] step_units,
  input wire logic home_req,
  output logic busy,
  output logic home_fail,
  output logic [7:0] position,
  input wire logic [NUM_PADS-1:0] gpio_in,
  output logic [NUM_PADS-1:0] gpio_out,
  output logic [NUM_PADS-1:0] gpio_oe_n
);
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [NUM_PADS-1:0] pad_meta_q;
  logic [NUM_PADS-1:0] pad_sync_q;
  cfg_s cfg_q;
  line_drive_s line;
  lens_state_e st_q;
  logic [15:0] pre_q;
  logic [15:0] wc_q;
  logic [7:0] units_q;
  logic [1:0] unit_step_q;
  logic [1:0] idx_q;
  logic dir_up_q;
  logic pi_pwr_q;
  logic pi_ref_q;
  logic [12:0] settle_unit_q;
  logic [2:0] settle_q;
  logic [7:0] search_q;
  logic [1:0] size_m1;
  logic mode16;
  logic [3:0] user_div;
  logic [3:0] auto_div;
  logic [3:0] eff_div;
  logic [15:0] pre_lim;
  logic [15:0] lim16;
  logic [15:0] wc_lim;
  logic pre_tick;
  logic step_tick;
  logic running;
  logic unit_done;
  logic pi_act;
  logic [7:0] home_pos;
  logic [3:0] phase;

  // reset released through two flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pad_meta_q <= '0;
      pad_sync_q <= '0;
    end else begin
      pad_meta_q <= gpio_in;
      pad_sync_q <= pad_meta_q;
    end
  end

  // configuration writes; word values take the high byte at the lower offset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else if (var_wr) begin
      unique case (var_addr)
        OFS_SI_CLK_QTR: cfg_q.si_clk_qtr[15:8] <= var_wdata;
        OFS_SI_CLK_QTR + 8'h01: cfg_q.si_clk_qtr[7:0] <= var_wdata;
        OFS_SI_ACK_EN: cfg_q.si_ack_en <= var_wdata;
        OFS_SI_ADDR: cfg_q.si_addr <= var_wdata;
        OFS_SI_CLK_PAD: cfg_q.si_clk_pad[15:8] <= var_wdata;
        OFS_SI_CLK_PAD + 8'h01: cfg_q.si_clk_pad[7:0] <= var_wdata;
        OFS_SI_DATA_PAD: cfg_q.si_data_pad[15:8] <= var_wdata;
        OFS_SI_DATA_PAD + 8'h01: cfg_q.si_data_pad[7:0] <= var_wdata;
        OFS_SM_EN_PAD: cfg_q.sm_en_pad[15:8] <= var_wdata;
        OFS_SM_EN_PAD + 8'h01: cfg_q.sm_en_pad[7:0] <= var_wdata;
        OFS_SM_PH0_PAD: cfg_q.sm_ph0_pad <= var_wdata;
        OFS_SM_PH1_PAD: cfg_q.sm_ph1_pad <= var_wdata;
        OFS_SM_PH2_PAD: cfg_q.sm_ph2_pad <= var_wdata;
        OFS_SM_PH3_PAD: cfg_q.sm_ph3_pad <= var_wdata;
        OFS_SM_QTR: cfg_q.sm_qtr <= var_wdata;
        OFS_SM_WF_CFG: cfg_q.sm_wf_cfg <= var_wdata;
        OFS_HS_EN_PAD: cfg_q.hs_en_pad[15:8] <= var_wdata;
        OFS_HS_EN_PAD + 8'h01: cfg_q.hs_en_pad[7:0] <= var_wdata;
        OFS_HS_IN_PAD: cfg_q.hs_in_pad[15:8] <= var_wdata;
        OFS_HS_IN_PAD + 8'h01: cfg_q.hs_in_pad[7:0] <= var_wdata;
        OFS_HS_OFFSET: cfg_q.hs_offset <= var_wdata;
        OFS_HS_CFG: cfg_q.hs_cfg <= var_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      var_rdata <= RST_BYTE;
    end else begin
      unique case (var_addr)
        OFS_SI_CLK_QTR: var_rdata <= cfg_q.si_clk_qtr[15:8];
        OFS_SI_CLK_QTR + 8'h01: var_rdata <= cfg_q.si_clk_qtr[7:0];
        OFS_SI_ACK_EN: var_rdata <= cfg_q.si_ack_en;
        OFS_SI_ADDR: var_rdata <= cfg_q.si_addr;
        OFS_SI_CLK_PAD: var_rdata <= cfg_q.si_clk_pad[15:8];
        OFS_SI_CLK_PAD + 8'h01: var_rdata <= cfg_q.si_clk_pad[7:0];
        OFS_SI_DATA_PAD: var_rdata <= cfg_q.si_data_pad[15:8];
        OFS_SI_DATA_PAD + 8'h01: var_rdata <= cfg_q.si_data_pad[7:0];
        OFS_SM_EN_PAD: var_rdata <= cfg_q.sm_en_pad[15:8];
        OFS_SM_EN_PAD + 8'h01: var_rdata <= cfg_q.sm_en_pad[7:0];
        OFS_SM_PH0_PAD: var_rdata <= cfg_q.sm_ph0_pad;
        OFS_SM_PH1_PAD: var_rdata <= cfg_q.sm_ph1_pad;
        OFS_SM_PH2_PAD: var_rdata <= cfg_q.sm_ph2_pad;
        OFS_SM_PH3_PAD: var_rdata <= cfg_q.sm_ph3_pad;
        OFS_SM_QTR: var_rdata <= cfg_q.sm_qtr;
        OFS_SM_WF_CFG: var_rdata <= cfg_q.sm_wf_cfg;
        OFS_HS_EN_PAD: var_rdata <= cfg_q.hs_en_pad[15:8];
        OFS_HS_EN_PAD + 8'h01: var_rdata <= cfg_q.hs_en_pad[7:0];
        OFS_HS_IN_PAD: var_rdata <= cfg_q.hs_in_pad[15:8];
        OFS_HS_IN_PAD + 8'h01: var_rdata <= cfg_q.hs_in_pad[7:0];
        OFS_HS_OFFSET: var_rdata <= cfg_q.hs_offset;
        OFS_HS_CFG: var_rdata <= cfg_q.hs_cfg;
        default: var_rdata <= RST_BYTE;
      endcase
    end
  end

  two_wire_sender u_sender (
    .clk(clk),
    .rst_n(rst_n),
    .qtr(cfg_q.si_clk_qtr),
    .ack_en(cfg_q.si_ack_en[0]),
    .addr(cfg_q.si_addr),
    .data(si_data),
    .start(si_req),
    .sda_in(|(pad_sync_q & cfg_q.si_data_pad)),
    .drive(line),
    .busy(si_busy),
    .nack(si_nack)
  );

  // waveform timing: two drive quarters per step, four steps per period
  assign mode16 = cfg_q.sm_wf_cfg[WF_MODE16_BIT];
  assign user_div = cfg_q.sm_wf_cfg[WF_DIV_LSB +: 4];
  assign lim16 = {7'h00, cfg_q.sm_qtr, 1'b1};
  // an 8-bit counter cannot hold the limit, so the computed divider halves it
  assign auto_div = (!mode16 && lim16 > 16'h00ff) ? 4'h1 : 4'h0;
  assign eff_div = (user_div > auto_div) ? user_div : auto_div;
  assign wc_lim = mode16 ? lim16 : {8'h00, 8'(lim16 >> eff_div)};
  // divider one scales by powers of two, divider two linearly
  assign pre_lim = cfg_q.sm_wf_cfg[WF_DIVSEL_BIT] ? {12'h000, eff_div} :
    ((16'h0001 << eff_div) - 16'h0001);
  assign pre_tick = (pre_q == pre_lim);
  assign step_tick = running && pre_tick && (wc_q == wc_lim);
  assign running = (units_q != 8'h00);

  always_comb begin
    unique case (cfg_q.sm_wf_cfg[WF_SIZE_LSB +: 2])
      2'h1: size_m1 = 2'h0;
      2'h2: size_m1 = 2'h1;
      default: size_m1 = 2'h3; // code 3 treated like 0
    endcase
  end
  assign unit_done = step_tick && (unit_step_q == size_m1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= RST_WORD;
      wc_q <= RST_WORD;
    end else if (!running) begin
      pre_q <= RST_WORD;
      wc_q <= RST_WORD;
    end else if (pre_tick) begin
      pre_q <= RST_WORD;
      wc_q <= (wc_q == wc_lim) ? RST_WORD : wc_q + 16'h0001;
    end else begin
      pre_q <= pre_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_q <= 2'h0;
      unit_step_q <= 2'h0;
    end else if (step_tick) begin
      idx_q <= dir_up_q ? idx_q + 2'h1 : idx_q - 2'h1;
      unit_step_q <= unit_done ? 2'h0 : unit_step_q + 2'h1;
    end
  end

  assign pi_act = cfg_q.hs_cfg[HS_POL_BIT] ? |(pad_sync_q & cfg_q.hs_in_pad) :
    ~|(pad_sync_q & cfg_q.hs_in_pad);
  assign home_pos = cfg_q.hs_cfg[HS_HOME_HI_BIT] ? POS_HI : POS_LO;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_unit_q <= 13'h0000;
    end else if (st_q != ST_SETTLE || settle_unit_q == SETTLE_UNIT_CYC - 13'h0001) begin
      settle_unit_q <= 13'h0000;
    end else begin
      settle_unit_q <= settle_unit_q + 13'h0001;
    end
  end

  // sequencer for plain moves and homing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      units_q <= RST_BYTE;
      dir_up_q <= 1'b0;
      pi_pwr_q <= 1'b0;
      pi_ref_q <= 1'b0;
      settle_q <= 3'h0;
      search_q <= RST_BYTE;
      position <= POS_LO;
      home_fail <= 1'b0;
      busy <= 1'b0;
    end else begin
      if (unit_done) begin
        units_q <= units_q - 8'h01;
        if (st_q == ST_MOVE) begin
          if (dir_up_q && position != POS_HI) begin
            position <= position + 8'h01;
          end else if (!dir_up_q && position != POS_LO) begin
            position <= position - 8'h01;
          end
        end
      end
      unique case (st_q)
        ST_IDLE: begin
          if (home_req) begin
            home_fail <= 1'b0;
            if (cfg_q.hs_cfg[HS_USE_BIT]) begin
              pi_pwr_q <= 1'b1;
              settle_q <= cfg_q.hs_cfg[HS_SETTLE_LSB +: 3];
              busy <= 1'b1;
              st_q <= ST_SETTLE;
            end else begin
              position <= home_pos;
            end
          end else if (step_req && step_units != 8'h00) begin
            units_q <= step_units;
            dir_up_q <= step_up;
            busy <= 1'b1;
            st_q <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (unit_done && units_q == 8'h01) begin
            busy <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        ST_SETTLE: begin
          if (settle_q == 3'h0) begin
            pi_ref_q <= pi_act;
            dir_up_q <= cfg_q.hs_cfg[HS_EDGE_HI_BIT];
            units_q <= 8'h01;
            search_q <= RST_BYTE;
            st_q <= ST_SEARCH;
          end else if (settle_unit_q == SETTLE_UNIT_CYC - 13'h0001) begin
            settle_q <= settle_q - 3'h1;
          end
        end
        ST_SEARCH: begin
          if (!running) begin
            if (pi_act != pi_ref_q) begin
              // home lies on the side where the sensor shows its home state
              if (pi_act != cfg_q.hs_cfg[HS_HOME_ACT_BIT]) begin
                dir_up_q <= ~dir_up_q;
              end
              units_q <= cfg_q.hs_offset;
              st_q <= ST_OFFSET;
            end else if (search_q == SEARCH_LIMIT) begin
              home_fail <= 1'b1;
              pi_pwr_q <= 1'b0;
              busy <= 1'b0;
              st_q <= ST_IDLE;
            end else begin
              search_q <= search_q + 8'h01;
              units_q <= 8'h01;
            end
          end
        end
        ST_OFFSET: begin
          if (!running) begin
            position <= home_pos;
            pi_pwr_q <= 1'b0;
            busy <= 1'b0;
            st_q <= ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // single-phase full-step pattern; phases drop low when idle to save current
  assign phase = running ? (4'h1 << idx_q) : 4'h0;

  // pad routing, one registered driver per pad
  for (genvar i = 0; i < NUM_PADS; i++) begin : g_pad
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        gpio_out[i] <= 1'b0;
        gpio_oe_n[i] <= 1'b1;
      end else if (cfg_q.si_clk_pad[i]) begin
        gpio_out[i] <= 1'b0;
        gpio_oe_n[i] <= ~line.scl_low;
      end else if (cfg_q.si_data_pad[i]) begin
        gpio_out[i] <= 1'b0;
        gpio_oe_n[i] <= ~line.sda_low;
      end else if (cfg_q.sm_en_pad[i]) begin
        gpio_out[i] <= running || st_q == ST_SEARCH || st_q == ST_OFFSET;
        gpio_oe_n[i] <= 1'b0;
      end else if (cfg_q.hs_en_pad[i]) begin
        gpio_out[i] <= pi_pwr_q;
        gpio_oe_n[i] <= 1'b0;
      end else if (i < NUM_PHASE_PADS && cfg_q.sm_ph0_pad[i % NUM_PHASE_PADS]) begin
        gpio_out[i] <= phase[0];
        gpio_oe_n[i] <= 1'b0;
      end else if (i < NUM_PHASE_PADS && cfg_q.sm_ph1_pad[i % NUM_PHASE_PADS]) begin
        gpio_out[i] <= phase[1];
        gpio_oe_n[i] <= 1'b0;
      end else if (i < NUM_PHASE_PADS && cfg_q.sm_ph2_pad[i % NUM_PHASE_PADS]) begin
        gpio_out[i] <= phase[2];
        gpio_oe_n[i] <= 1'b0;
      end else if (i < NUM_PHASE_PADS && cfg_q.sm_ph3_pad[i % NUM_PHASE_PADS]) begin
        gpio_out[i] <= phase[3];
        gpio_oe_n[i] <= 1'b0;
      end else begin
        gpio_out[i] <= 1'b0;
        gpio_oe_n[i] <= 1'b1;
      end
    end
  end

endmodule // lens_actuator_drive

//--- design/lens_drive_pkg.sv
// shared constants, types and register map for the lens actuator drive block
package lens_drive_pkg;

  // byte offsets in the driver variable space; 16-bit values are high byte first
  localparam logic [7:0] OFS_SI_CLK_QTR = 8'h1f;
  localparam logic [7:0] OFS_SI_ACK_EN = 8'h21;
  localparam logic [7:0] OFS_SI_ADDR = 8'h22;
  localparam logic [7:0] OFS_SI_CLK_PAD = 8'h1b;
  localparam logic [7:0] OFS_SI_DATA_PAD = 8'h1d;
  localparam logic [7:0] OFS_SM_EN_PAD = 8'h23;
  localparam logic [7:0] OFS_SM_PH0_PAD = 8'h25;
  localparam logic [7:0] OFS_SM_PH1_PAD = 8'h26;
  localparam logic [7:0] OFS_SM_PH2_PAD = 8'h27;
  localparam logic [7:0] OFS_SM_PH3_PAD = 8'h28;
  localparam logic [7:0] OFS_SM_QTR = 8'h29;
  localparam logic [7:0] OFS_SM_WF_CFG = 8'h2b;
  localparam logic [7:0] OFS_HS_EN_PAD = 8'h2c;
  localparam logic [7:0] OFS_HS_IN_PAD = 8'h2e;
  localparam logic [7:0] OFS_HS_OFFSET = 8'h30;
  localparam logic [7:0] OFS_HS_CFG = 8'h31;

  // field positions in stepper_waveform_config
  localparam int WF_SIZE_LSB = 0;
  localparam int WF_MODE16_BIT = 2;
  localparam int WF_DIVSEL_BIT = 3;
  localparam int WF_DIV_LSB = 4;
  // field positions in home_sensor_config
  localparam int HS_USE_BIT = 0;
  localparam int HS_EDGE_HI_BIT = 1;
  localparam int HS_POL_BIT = 2;
  localparam int HS_HOME_ACT_BIT = 3;
  localparam int HS_HOME_HI_BIT = 4;
  localparam int HS_SETTLE_LSB = 5;

  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] POS_LO = 8'h00;
  localparam logic [7:0] POS_HI = 8'hff;
  localparam logic [7:0] SEARCH_LIMIT = 8'hff;
  localparam int NUM_PADS = 16;
  localparam int NUM_PHASE_PADS = 8;

  // time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_UNIT_NS = 1000;
  localparam int SETTLE_UNIT_CYC_I = (SETTLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [12:0] SETTLE_UNIT_CYC = 13'(SETTLE_UNIT_CYC_I);

  typedef struct packed {
    logic [15:0] si_clk_qtr;
    logic [7:0] si_ack_en;
    logic [7:0] si_addr;
    logic [15:0] si_clk_pad;
    logic [15:0] si_data_pad;
    logic [15:0] sm_en_pad;
    logic [7:0] sm_ph0_pad;
    logic [7:0] sm_ph1_pad;
    logic [7:0] sm_ph2_pad;
    logic [7:0] sm_ph3_pad;
    logic [7:0] sm_qtr;
    logic [7:0] sm_wf_cfg;
    logic [15:0] hs_en_pad;
    logic [15:0] hs_in_pad;
    logic [7:0] hs_offset;
    logic [7:0] hs_cfg;
  } cfg_s;

  typedef struct packed {
    logic scl_low;
    logic sda_low;
  } line_drive_s;

  typedef enum logic [1:0] {
    TW_IDLE = 2'b00,
    TW_START = 2'b01,
    TW_BITS = 2'b10,
    TW_STOP = 2'b11
  } tw_state_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_MOVE = 3'b001,
    ST_SETTLE = 3'b010,
    ST_SEARCH = 3'b011,
    ST_OFFSET = 3'b100
  } lens_state_e;

endpackage

//--- design/two_wire_sender.sv
// two-wire write sender: start, address byte, two data bytes, stop
`timescale 1ns/1ns
module two_wire_sender import lens_drive_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] qtr,
  input wire logic ack_en,
  input wire logic [7:0] addr,
  input wire logic [15:0] data,
  input wire logic start,
  input wire logic sda_in,
  output line_drive_s drive,
  output logic busy,
  output logic nack
);
  tw_state_e st_q;
  logic [15:0] qcnt_q;
  logic [1:0] q_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [23:0] shift_q;
  logic tick;

  // one quarter of the line clock lasts qtr+1 cycles
  assign tick = (qcnt_q == qtr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      qcnt_q <= RST_WORD;
    end else if (st_q == TW_IDLE || tick) begin
      qcnt_q <= RST_WORD;
    end else begin
      qcnt_q <= qcnt_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= TW_IDLE;
      drive <= '0;
      busy <= 1'b0;
      nack <= 1'b0;
      q_q <= 2'h0;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      shift_q <= 24'h000000;
    end else begin
      unique case (st_q)
        TW_IDLE: begin
          if (start) begin
            st_q <= TW_START;
            busy <= 1'b1;
            nack <= 1'b0;
            drive.sda_low <= 1'b1;
            shift_q <= {addr, data};
            q_q <= 2'h0;
          end
        end
        TW_START: begin
          if (tick) begin
            drive.scl_low <= 1'b1;
            drive.sda_low <= ~shift_q[23];
            st_q <= TW_BITS;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
            q_q <= 2'h0;
          end
        end
        TW_BITS: begin
          if (tick) begin
            q_q <= q_q + 2'h1;
            unique case (q_q)
              2'h0: ;
              2'h1: drive.scl_low <= 1'b0;
              2'h2: ;
              2'h3: begin
                drive.scl_low <= 1'b1;
                if (bit_q == 4'h8) begin
                  // ack slot ends; released line read high means refused
                  if ((ack_en && sda_in) || byte_q == 2'h2) begin
                    nack <= ack_en & sda_in;
                    drive.sda_low <= 1'b1;
                    st_q <= TW_STOP;
                  end else begin
                    byte_q <= byte_q + 2'h1;
                    bit_q <= 4'h0;
                    drive.sda_low <= ~shift_q[23];
                  end
                end else begin
                  shift_q <= {shift_q[22:0], 1'b0};
                  bit_q <= bit_q + 4'h1;
                  drive.sda_low <= (bit_q == 4'h7) ? 1'b0 : ~shift_q[22];
                end
              end
            endcase
          end
        end
        TW_STOP: begin
          if (tick) begin
            if (drive.scl_low) begin
              drive.scl_low <= 1'b0;
            end else begin
              drive.sda_low <= 1'b0;
              busy <= 1'b0;
              st_q <= TW_IDLE;
            end
          end
        end
      endcase
    end
  end

endmodule // two_wire_sender

//--- verification/lens_actuator_drive_sva.sv
// port assertions for the lens actuator drive
`timescale 1ns/1ns
module lens_actuator_drive_sva import lens_drive_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] var_addr,
  input wire logic var_wr,
  input wire logic [7:0] var_wdata,
  input wire logic [7:0] var_rdata,
  input wire logic si_req,
  input wire logic si_busy,
  input wire logic si_nack,
  input wire logic step_req,
  input wire logic [7:0] step_units,
  input wire logic home_req,
  input wire logic busy,
  input wire logic home_fail,
  input wire logic [7:0] position
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  read_back_a: assert property (var_wr && var_addr == OFS_SI_ADDR ##1
    !var_wr && var_addr == OFS_SI_ADDR |=> var_rdata == $past(var_wdata, 2)) else $error("no read back");
  frame_start_a: assert property (si_req && !si_busy |=> si_busy && !si_nack)
    else $error("frame did not start");
  frame_min_a: assert property ($rose(si_busy) |-> si_busy [*8])
    else $error("frame too short");
  frame_end_a: assert property ($rose(si_busy) |-> ##[30:1000] !si_busy)
    else $error("frame never ended");
  move_start_a: assert property (step_req && !busy && !home_req && step_units != 8'h00
    |=> busy) else $error("move did not start");
  move_zero_a: assert property (step_req && !busy && !home_req && step_units == 8'h00
    |=> !busy) else $error("empty move started");
  home_clear_a: assert property (home_req && !busy |=> !home_fail)
    else $error("home fail not cleared");
  pos_hold_a: assert property (!busy [*3] |-> $stable(position))
    else $error("position moved while idle");
  pos_step_a: assert property (busy && $changed(position) |-> position == $past(position) + 8'h01
    || position == $past(position) - 8'h01 || position == POS_LO || position == POS_HI)
    else $error("position jumped");
endmodule // lens_actuator_drive_sva
bind lens_actuator_drive lens_actuator_drive_sva lens_actuator_drive_sva_inst (.*);

//--- verification/lens_partner.sv
// far side: two-wire actuator receiver, stepper phase counter, home sensor
`timescale 1ns/1ns
module lens_partner (
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe_n,
  input wire logic nack_mode,
  input wire logic sens_act,
  input wire logic sens_pol,
  output logic [15:0] gpio_in,
  output logic [23:0] rx,
  output int steps
);
  logic ack_low = 1'b0;
  logic [7:0] sh = 8'h00;
  int n = 0;
  // open-drain lines with pull-ups on pads 0 and 1
  wire scl = gpio_oe_n[0] | gpio_out[0];
  wire sda = (gpio_oe_n[1] | gpio_out[1]) & !ack_low;
  wire powered = !gpio_oe_n[7] && gpio_out[7];
  // an unpowered sensor reads inactive
  wire sens = (powered & sens_act) ^ !sens_pol;
  assign gpio_in = {7'h00, sens, 6'h00, sda, scl};
  initial rx = 24'h000000;
  initial steps = 0;
  // data may move in the same step as the clock falls; look again once both settled
  always @(negedge sda) begin
    #1;
    if (scl) n = 0;
  end
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n++;
  end
  always @(negedge scl) begin
    if (n == 8) ack_low = !nack_mode;
    else if (n == 9) begin
      ack_low = 1'b0;
      rx = {rx[15:0], sh};
      n = 0;
    end
  end
  always @(posedge gpio_out[2], posedge gpio_out[3], posedge gpio_out[4], posedge gpio_out[5])
    steps++;
endmodule // lens_partner

//--- verification/lens_actuator_drive_tb.sv
// testbench for the lens actuator drive block
`timescale 1ns/1ns
module lens_actuator_drive_tb import lens_drive_pkg::*;;
  logic clk = 1'b0, arst_n = 1'b0, var_wr = 1'b0, si_req = 1'b0, step_req = 1'b0, step_up = 1'b0;
  logic home_req = 1'b0, busy, si_busy, si_nack, home_fail;
  logic nack_mode = 1'b0, sens_act = 1'b0, sens_pol = 1'b0;
  logic [7:0] var_addr = 8'h00, var_wdata = 8'h00, var_rdata, step_units = 8'h00, position, p;
  logic [15:0] si_data = 16'h0000, gpio_in, gpio_out, gpio_oe_n;
  logic [23:0] rx;
  logic [7:0] wf_tab [6] = '{8'h04, 8'h05, 8'h06, 8'h24, 8'h2d, 8'h21};
  int mismatches = 0, n_tests = 0, steps, cyc, c1, ns, per;
  always #4 clk = ~clk;
  lens_actuator_drive lens_actuator_drive_inst (.*);
  lens_partner lens_partner_inst (.*);
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    var_addr = a;
    var_wr = 1'b1;
    var_wdata = d;
    @(negedge clk);
    var_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    var_addr = a;
    @(negedge clk);
    chk(var_rdata, d);
  endtask
  task automatic wait_idle(input int lim);
    cyc = 0;
    while ((busy || si_busy) && cyc < lim) begin
      if (cyc == 2 && busy) chk({gpio_out[6], gpio_oe_n[6]}, 2'b10);
      @(negedge clk);
      cyc++;
    end
    if (cyc >= lim) mismatches++;
  endtask
  task automatic send(input logic [15:0] d, input logic nk, input logic en);
    nack_mode = nk;
    si_data = d;
    si_req = 1'b1;
    @(negedge clk);
    si_req = 1'b0;
    wait_idle(3000);
    chk(si_nack, nk & en);
    if (!(nk & en)) chk(rx, {8'ha6, d});
  endtask
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    for (int a = 8'h1b; a < 8'h33; a++) rd(8'(a), 8'h00);
    wr(8'h2a, 8'h5a);
    rd(8'h2a, 8'h00);
    wr(OFS_SI_CLK_QTR + 8'h01, 8'h01);
    wr(OFS_SI_ACK_EN, 8'h01);
    wr(OFS_SI_ADDR, 8'ha6);
    wr(OFS_SI_CLK_PAD + 8'h01, 8'h01);
    wr(OFS_SI_DATA_PAD + 8'h01, 8'h02);
    rd(OFS_SI_ADDR, 8'ha6);
    send(16'h3c81, 1'b0, 1'b1);
    c1 = cyc;
    send(16'h1234, 1'b1, 1'b1);
    wr(OFS_SI_ACK_EN, 8'h00);
    send(16'h5a0f, 1'b1, 1'b0);
    wr(OFS_SI_CLK_QTR + 8'h01, 8'h03);
    send(16'h00ff, 1'b0, 1'b0);
    chk(cyc > c1 * 3 / 2, 1'b1);
    wr(OFS_SM_PH0_PAD, 8'h04);
    wr(OFS_SM_PH1_PAD, 8'h08);
    wr(OFS_SM_PH2_PAD, 8'h10);
    wr(OFS_SM_PH3_PAD, 8'h20);
    wr(OFS_SM_EN_PAD + 8'h01, 8'h40);
    wr(OFS_SM_QTR, 8'h01);
    p = 8'h00;
    foreach (wf_tab[i]) begin
      wr(OFS_SM_WF_CFG, wf_tab[i]);
      // cycles per step at q=1: counter limit 3, shifted down by the divider in 8-bit mode
      per = (wf_tab[i][2] ? 4 : (3 >> wf_tab[i][7:4]) + 1) *
        (wf_tab[i][3] ? wf_tab[i][7:4] + 1 : 1 << wf_tab[i][7:4]);
      ns = 4 * (wf_tab[i][1:0] == 2'd0 ? 4 : wf_tab[i][1:0]);
      c1 = steps;
      step_units = 8'h04;
      step_up = !i[0];
      step_req = 1'b1;
      @(negedge clk);
      step_req = 1'b0;
      wait_idle(3000);
      chk(steps - c1, ns);
      chk(cyc >= ns * per - 2 && cyc <= ns * per + per + 2, 1'b1);
      p = step_up ? p + 8'h04 : p - 8'h04;
      // enable pad trails the last step by its output register
      @(negedge clk);
      chk({gpio_out[6], position}, {1'b0, p});
    end
    step_units = 8'h00;
    step_req = 1'b1;
    @(negedge clk);
    step_req = 1'b0;
    @(negedge clk);
    chk(busy, 1'b0);
    wr(OFS_HS_EN_PAD + 8'h01, 8'h80);
    wr(OFS_HS_IN_PAD, 8'h01);
    wr(OFS_HS_OFFSET, 8'h03);
    for (int k = 0; k < 2; k++) begin
      // sensor level settles through the pad synchroniser before homing samples it
      sens_pol = (k == 0);
      sens_act = 1'b0;
      wr(OFS_HS_CFG, k ? 8'h19 : 8'h0d);
      home_req = 1'b1;
      @(negedge clk);
      home_req = 1'b0;
      repeat (40) @(negedge clk);
      chk({busy, gpio_out[7]}, 2'b11);
      sens_act = 1'b1;
      wait_idle(20000);
      chk({home_fail, position}, {1'b0, k ? 8'hff : 8'h00});
    end
    finish_test();
  end
endmodule // lens_actuator_drive_tb
